// ===== rtl/csw_pkg.sv
// constants and types for the chip select 2/3 wait controller
package csw_pkg;
    // register map
    localparam logic [31:0] CTRL_ADDR   = 32'hFFFF_E484;
    localparam logic [31:0] STAT_ADDR   = 32'hFFFF_E488;
    localparam logic [31:0] CTRL_RESET  = 32'h0005_0805;
    localparam logic [31:0] CTRL_WMASK  = 32'h0BDF_0FDF;
    // space two fields
    localparam int S2_WAIT_LSB  = 0;
    localparam int S2_WIDTH_BIT = 4;
    localparam int S2_WAVE_LSB  = 6;
    localparam int S2_RCV_LSB   = 8;
    localparam int S2_SCOPE_BIT = 10;
    localparam int S2_EN_BIT    = 11;
    // space three fields
    localparam int S3_WAIT_LSB  = 16;
    localparam int S3_WIDTH_BIT = 20;
    localparam int S3_WAVE_LSB  = 22;
    localparam int S3_RCV_LSB   = 24;
    localparam int S3_EN_BIT    = 27;
    // status bits
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_STROBE_BIT = 1;
    localparam int ST_RECOV_BIT  = 2;
    localparam int ST_SPACE_BIT  = 3;
    localparam int ST_SEL_BIT    = 4;
    localparam int ST_WAVE_BIT   = 5;
    // field codes
    localparam logic [3:0] WAIT_NONE = 4'h0;
    localparam logic [3:0] WAIT_EXT  = 4'hF;
    localparam logic [1:0] RCV_TWO   = 2'h0;
    localparam logic [1:0] RCV_ONE   = 2'h1;
    localparam logic [1:0] RCV_NONE  = 2'h2;
    localparam logic [1:0] WAVE_ROM  = 2'h0;
    // access sequencer states
    typedef enum logic [2:0] {
        CSW_IDLE    = 3'b000,
        CSW_ACCESS  = 3'b001,
        CSW_WAITFIX = 3'b010,
        CSW_WAITPIN = 3'b011,
        CSW_RECOV   = 3'b100
    } csw_state_t;
endpackage : csw_pkg

// ===== rtl/csw_seq_if.sv
// carrier between the top and the access sequencer
`timescale 1ns/1ps
`default_nettype none
interface csw_seq_if;
    logic       start;
    logic       read;
    logic [3:0] wait_code;
    logic [1:0] rcv_code;
    logic       wait_act;
    logic       strobe;
    logic       done;
    logic       busy;
    logic       recov;
    modport ctl (output start, read, wait_code, rcv_code, wait_act,
                 input  strobe, done, busy, recov);
    modport seq (input  start, read, wait_code, rcv_code, wait_act,
                 output strobe, done, busy, recov);
endinterface : csw_seq_if
`default_nettype wire

// ===== rtl/csw_seq.sv
// access sequencer: strobe, wait states and read recovery
`timescale 1ns/1ps
`default_nettype none
module csw_seq (
    input wire logic clk,
    input wire logic rst_n,
    csw_seq_if.seq   sq
);
    csw_pkg::csw_state_t state;
    csw_pkg::csw_state_t next_state;
    logic [3:0]          wait_left;
    logic [1:0]          rec_left;
    logic                ext_mode;
    logic                is_read;
    logic                finish;

    // dummy cycles for a recovery code, reserved code treated as longest
    function automatic logic [1:0] dummy_count(input logic [1:0] code);
        logic [1:0] n;
        n = 2'h2;
        if (code == csw_pkg::RCV_ONE) begin
            n = 2'h1;
        end else if (code == csw_pkg::RCV_NONE) begin
            n = 2'h0;
        end
        return n;
    endfunction : dummy_count

    // last strobe cycle of the access
    assign finish = (state == csw_pkg::CSW_ACCESS && wait_left == 4'h0)
                 || (state == csw_pkg::CSW_WAITFIX && wait_left == 4'h1
                     && !(ext_mode && sq.wait_act))
                 || (state == csw_pkg::CSW_WAITPIN && !sq.wait_act);

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            csw_pkg::CSW_IDLE: begin
                if (sq.start) begin
                    next_state = csw_pkg::CSW_ACCESS;
                end
            end
            csw_pkg::CSW_ACCESS, csw_pkg::CSW_WAITFIX, csw_pkg::CSW_WAITPIN: begin
                if (finish) begin
                    // dummy cycles only after reads
                    next_state = (is_read && rec_left != 2'h0) ? csw_pkg::CSW_RECOV
                                                                : csw_pkg::CSW_IDLE;
                end else if (state == csw_pkg::CSW_ACCESS) begin
                    next_state = csw_pkg::CSW_WAITFIX;
                end else if (state == csw_pkg::CSW_WAITFIX && wait_left == 4'h1) begin
                    next_state = csw_pkg::CSW_WAITPIN;
                end
            end
            csw_pkg::CSW_RECOV: begin
                if (rec_left == 2'h1) begin
                    next_state = csw_pkg::CSW_IDLE;
                end
            end
            default: next_state = csw_pkg::CSW_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= csw_pkg::CSW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // wait counter, extended mode starts with one fixed wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_left <= 4'h0;
            ext_mode  <= 1'b0;
        end else if (state == csw_pkg::CSW_IDLE && sq.start) begin
            ext_mode  <= (sq.wait_code == csw_pkg::WAIT_EXT);
            wait_left <= (sq.wait_code == csw_pkg::WAIT_EXT) ? 4'h1 : sq.wait_code;
        end else if (state == csw_pkg::CSW_WAITFIX) begin
            wait_left <= wait_left - 4'h1;
        end
    end

    // recovery counter and access direction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_left <= 2'h0;
            is_read  <= 1'b0;
        end else if (state == csw_pkg::CSW_IDLE && sq.start) begin
            rec_left <= dummy_count(sq.rcv_code);
            is_read  <= sq.read;
        end else if (state == csw_pkg::CSW_RECOV) begin
            rec_left <= rec_left - 2'h1;
        end
    end

    // status towards the top
    assign sq.strobe = (state == csw_pkg::CSW_ACCESS) || (state == csw_pkg::CSW_WAITFIX)
                    || (state == csw_pkg::CSW_WAITPIN);
    assign sq.done   = sq.strobe && finish;
    assign sq.busy   = (state != csw_pkg::CSW_IDLE);
    assign sq.recov  = (state == csw_pkg::CSW_RECOV);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rec_two_s;
        sq.recov [*2] ##1 !sq.busy;
    endsequence
    sequence rec_one_s;
        sq.recov ##1 !sq.busy;
    endsequence

    rec_two_a: assert property (sq.done && is_read && rec_left == 2'h2 |=> rec_two_s)
        else $error("two dummy cycles expected");
    rec_one_a: assert property (sq.done && is_read && rec_left == 2'h1 |=> rec_one_s)
        else $error("one dummy cycle expected");
    rec_none_a: assert property (sq.done && rec_left == 2'h0 |=> !sq.busy)
        else $error("no dummy cycle expected");
    rec_write_a: assert property (sq.done && !is_read |=> !sq.busy)
        else $error("recovery after a write");
    rec_strobe_a: assert property (sq.recov |-> !sq.strobe)
        else $error("strobe during recovery");
endmodule : csw_seq
`default_nettype wire

// ===== rtl/csw_cs23_top.sv
// chip select 2/3 configuration, decode and wait-state timing
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csw_cs23_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        acc_req,
    input  wire logic        acc_space,
    input  wire logic        acc_read,
    input  wire logic        acc_in_window,
    output logic             acc_ready,
    output logic             acc_done,
    input  wire logic        wait_pin_b,
    output logic             chip_select_two_b,
    output logic             chip_select_three_b,
    output logic             bus_width_8,
    output logic             recovery_active
);
    logic        rst_meta;
    logic        rst_n;
    logic        wait_meta;
    logic        wait_sync_b;
    logic [31:0] chip_select_two_three_control;
    logic        start;
    logic        cur_space;
    logic        cur_sel;
    logic        next_sel;
    logic        next_width;
    logic        wave_bad;
    logic [31:0] status;

    csw_seq_if sq ();

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // wait pin synchroniser, idle high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_meta   <= 1'b1;
            wait_sync_b <= 1'b1;
        end else begin
            wait_meta   <= wait_pin_b;
            wait_sync_b <= wait_meta;
        end
    end

    // control register, reserved bits held at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_select_two_three_control <= csw_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == csw_pkg::CTRL_ADDR) begin
            chip_select_two_three_control <= reg_wdata & csw_pkg::CTRL_WMASK;
        end
    end

    // flags a waveform code other than rom/ram in either space
    assign wave_bad = (chip_select_two_three_control[csw_pkg::S2_WAVE_LSB +: 2]
                       != csw_pkg::WAVE_ROM)
                   || (chip_select_two_three_control[csw_pkg::S3_WAVE_LSB +: 2]
                       != csw_pkg::WAVE_ROM);

    // status word
    always_comb begin
        status = 32'h0000_0000;
        status[csw_pkg::ST_BUSY_BIT]   = sq.busy;
        status[csw_pkg::ST_STROBE_BIT] = sq.strobe;
        status[csw_pkg::ST_RECOV_BIT]  = sq.recov;
        status[csw_pkg::ST_SPACE_BIT]  = cur_space;
        status[csw_pkg::ST_SEL_BIT]    = cur_sel;
        status[csw_pkg::ST_WAVE_BIT]   = wave_bad;
    end

    // read data one cycle after the strobe; control is write-only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd && reg_addr == csw_pkg::STAT_ADDR) begin
            reg_rdata <= status;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // access request handshake
    assign acc_ready = !sq.busy;
    assign start     = acc_req && acc_ready;

    // per-space fields routed to the sequencer
    assign sq.start     = start;
    assign sq.read      = acc_read;
    assign sq.wait_act  = !wait_sync_b;
    assign sq.wait_code = acc_space
        ? chip_select_two_three_control[csw_pkg::S3_WAIT_LSB +: 4]
        : chip_select_two_three_control[csw_pkg::S2_WAIT_LSB +: 4];
    assign sq.rcv_code  = acc_space
        ? chip_select_two_three_control[csw_pkg::S3_RCV_LSB +: 2]
        : chip_select_two_three_control[csw_pkg::S2_RCV_LSB +: 2];

    // select decode from enable, scope and window
    always_comb begin
        if (acc_space) begin
            next_sel   = chip_select_two_three_control[csw_pkg::S3_EN_BIT]
                      && acc_in_window;
            next_width = chip_select_two_three_control[csw_pkg::S3_WIDTH_BIT];
        end else begin
            next_sel   = chip_select_two_three_control[csw_pkg::S2_EN_BIT]
                      && (!chip_select_two_three_control[csw_pkg::S2_SCOPE_BIT]
                          || acc_in_window);
            next_width = chip_select_two_three_control[csw_pkg::S2_WIDTH_BIT];
        end
    end

    // access context latched when taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_space   <= 1'b0;
            cur_sel     <= 1'b0;
            bus_width_8 <= 1'b0;
        end else if (start) begin
            cur_space   <= acc_space;
            cur_sel     <= next_sel;
            bus_width_8 <= next_width;
        end
    end

    // selects are active low during the strobe
    assign chip_select_two_b   = !(sq.strobe && cur_sel && !cur_space);
    assign chip_select_three_b = !(sq.strobe && cur_sel && cur_space);
    assign acc_done            = sq.done;
    assign recovery_active     = sq.recov;

    csw_seq u_seq (
        .clk   (clk),
        .rst_n (rst_n),
        .sq    (sq)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence strobe_wait1_s;
        (sq.strobe && !acc_done) ##1 acc_done;
    endsequence
    sequence strobe_wait2_s;
        (sq.strobe && !acc_done) [*2] ##1 acc_done;
    endsequence
    sequence strobe_wait3_s;
        (sq.strobe && !acc_done) [*3] ##1 acc_done;
    endsequence
    sequence strobe_wait5_s;
        (sq.strobe && !acc_done) [*5] ##1 acc_done;
    endsequence

    wait_zero_a: assert property (start && sq.wait_code == 4'h0 |=> acc_done)
        else $error("code 0000 must end in one cycle");
    wait_one_a: assert property (start && sq.wait_code == 4'h1 |=> strobe_wait1_s)
        else $error("code 0001 must add one wait");
    wait_two_a: assert property (start && sq.wait_code == 4'h2 |=> strobe_wait2_s)
        else $error("code 0010 must add two waits");
    wait_three_a: assert property (start && sq.wait_code == 4'h3 |=> strobe_wait3_s)
        else $error("code 0011 must add three waits");
    wait_seven_a: assert property (start && sq.wait_code == 4'h7
                                   |=> (sq.strobe && !acc_done) [*7] ##1 acc_done)
        else $error("code 0111 must add seven waits");
    wait_ext_a: assert property (start && sq.wait_code == 4'hF |=> !acc_done)
        else $error("code 1111 needs at least one wait");
    wait_hold_a: assert property (sq.strobe && $past(sq.strobe) && sq.wait_act
                                  && $past(sq.wait_act) && u_seq.ext_mode |-> !acc_done)
        else $error("access ended while wait asserted");
    bus_width_a: assert property (start |=> bus_width_8 == $past(next_width))
        else $error("bus width not taken from its space");
    cs2_off_a: assert property (start && !acc_space
                                && !chip_select_two_three_control[csw_pkg::S2_EN_BIT]
                                |=> chip_select_two_b)
        else $error("disabled select two asserted");
    cs2_whole_a: assert property (start && !acc_space
                                  && chip_select_two_three_control[csw_pkg::S2_EN_BIT]
                                  && !chip_select_two_three_control[csw_pkg::S2_SCOPE_BIT]
                                  |=> !chip_select_two_b)
        else $error("select two must cover whole space");
    cs3_window_a: assert property (start && acc_space && !acc_in_window
                                   |=> chip_select_three_b)
        else $error("select three outside window");
    wait_five_a: assert property (start && sq.wait_code == 4'h5 |=> strobe_wait5_s)
        else $error("code 0101 must add five waits");
    cs3_off_a: assert property (start && acc_space
                                && !chip_select_two_three_control[csw_pkg::S3_EN_BIT]
                                |=> chip_select_three_b)
        else $error("disabled select three asserted");
    cs2_window_a: assert property (start && !acc_space
                                   && chip_select_two_three_control[csw_pkg::S2_SCOPE_BIT]
                                   && !acc_in_window
                                   |=> chip_select_two_b)
        else $error("select two outside its window");
    sel_strobe_a: assert property (!sq.strobe
                                   |-> chip_select_two_b && chip_select_three_b)
        else $error("select outside the strobe");
    rec_ready_a: assert property (recovery_active |-> !acc_ready)
        else $error("access taken during recovery");
endmodule : csw_cs23_top
`default_nettype wire

// ===== dv/csw_mem_model.sv
// external rom/ram model that drives the wait pin
`timescale 1ns/1ps
`default_nettype none
module csw_mem_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sel_b,
    input  wire logic       armed,
    input  wire logic [3:0] hold,
    output logic            wait_b
);
    logic [3:0] cnt;

    // cycles spent selected since the device became busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else if (!armed) begin
            cnt <= 4'h0;
        end else if (!sel_b && cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end

    // busy device holds wait from before the select until served, so the
    // two-cycle pin synchroniser sees it; the pull-up keeps the pin high otherwise
    assign wait_b = ~(armed && (cnt < hold));
endmodule : csw_mem_model
`default_nettype wire

// ===== dv/csw_cs23_tb_top.sv
// self-checking bench for the chip select 2/3 wait controller
`timescale 1ns/1ps
`default_nettype none
module csw_cs23_tb_top;
    logic        clk           = 1'b0;
    logic        rst_b         = 1'b0;
    logic [31:0] reg_addr      = 32'h0000_0000;
    logic [31:0] reg_wdata     = 32'h0000_0000;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic        acc_req       = 1'b0;
    logic        acc_space     = 1'b0;
    logic        acc_read      = 1'b0;
    logic        acc_in_window = 1'b0;
    logic        armed         = 1'b0;
    logic [3:0]  hold          = 4'h0;
    logic [31:0] reg_rdata;
    logic        acc_ready;
    logic        acc_done;
    logic        wait_pin_b;
    logic        chip_select_two_b;
    logic        chip_select_three_b;
    logic        bus_width_8;
    logic        recovery_active;
    logic        bw;
    logic [31:0] rd;
    int          n_fail        = 0;
    int          total_checks  = 0;
    int          lat;
    int          sel;
    int          read_recovery_count;

    // free-running clock
    always #25 clk = ~clk;

    csw_cs23_top u_csw_cs23_top (
        .clk                 (clk),
        .rst_b               (rst_b),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .acc_req             (acc_req),
        .acc_space           (acc_space),
        .acc_read            (acc_read),
        .acc_in_window       (acc_in_window),
        .acc_ready           (acc_ready),
        .acc_done            (acc_done),
        .wait_pin_b          (wait_pin_b),
        .chip_select_two_b   (chip_select_two_b),
        .chip_select_three_b (chip_select_three_b),
        .bus_width_8         (bus_width_8),
        .recovery_active     (recovery_active)
    );

    csw_mem_model u_csw_mem_model (
        .clk    (clk),
        .rst_n  (rst_b),
        .sel_b  (chip_select_two_b & chip_select_three_b),
        .armed  (armed),
        .hold   (hold),
        .wait_b (wait_pin_b)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : reg_write

    task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : reg_read

    // one space's half of the control word; waveform field kept at 00
    function automatic logic [15:0] fld(input logic [3:0] w, input logic [1:0] r,
                                        input logic b, input logic e, input logic s);
        fld = 16'h0000;
        fld[csw_pkg::S2_WAIT_LSB +: 4] = w;
        fld[csw_pkg::S2_RCV_LSB +: 2]  = r;
        fld[csw_pkg::S2_WIDTH_BIT]     = b;
        fld[csw_pkg::S2_EN_BIT]        = e;
        fld[csw_pkg::S2_SCOPE_BIT]     = s;
    endfunction : fld

    // one access: latency to done, select cycles, width, dummy cycles after
    task automatic acc(input logic sp, input logic rd_op, input logic win);
        int i;
        acc_space     <= sp;
        acc_read      <= rd_op;
        acc_in_window <= win;
        acc_req       <= 1'b1;
        @(posedge clk);
        chk(32'(acc_ready), 32'h0000_0001);
        acc_req <= 1'b0;
        lat = 0;
        sel = 0;
        read_recovery_count = 0;
        for (i = 1; i <= 40 && lat == 0; i++) begin
            @(posedge clk);
            if (i == 1) bw = bus_width_8;
            if ((sp ? chip_select_three_b : chip_select_two_b) === 1'b0) sel++;
            if ((sp ? chip_select_two_b : chip_select_three_b) !== 1'b1) sel += 100;
            if (acc_done === 1'b1) lat = i;
        end
        if (lat == 0) begin
            chk(32'h0000_0000, 32'h0000_0001);
            end_sim();
        end
        for (i = 0; i < 40 && acc_ready !== 1'b1; i++) begin
            @(posedge clk);
            if (recovery_active === 1'b1) read_recovery_count++;
        end
        if (acc_ready !== 1'b1) begin
            chk(32'h0000_0000, 32'h0000_0001);
            end_sim();
        end
    endtask : acc

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        chk(32'(acc_ready), 32'h0000_0001);
        chk(32'({chip_select_two_b, chip_select_three_b}), 32'h0000_0003);
        chk(32'({bus_width_8, recovery_active}), 32'h0000_0000);
        chk(reg_rdata, 32'h0000_0000);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        // reset configuration: space two enabled, code 0101
        acc(1'b0, 1'b0, 1'b0);
        chk(32'(lat), 32'h0000_0006);
        chk(32'(sel), 32'h0000_0006);
        // space three disabled after reset, same wait code
        acc(1'b1, 1'b0, 1'b1);
        chk(32'(lat), 32'h0000_0006);
        chk(32'(sel), 32'h0000_0000);
        reg_read(csw_pkg::STAT_ADDR, rd);
        chk(rd, 32'h0000_0001 << csw_pkg::ST_SPACE_BIT);
        // write-only control, unmapped read and write
        reg_read(csw_pkg::CTRL_ADDR, rd);
        chk(rd, 32'h0000_0000);
        reg_read(32'h0000_0010, rd);
        chk(rd, 32'h0000_0000);
        reg_write(32'hFFFF_E480, 32'h0000_0800);
        acc(1'b0, 1'b0, 1'b0);
        chk(32'(lat), 32'h0000_0006);
        // fixed wait codes on both spaces
        for (int w = 0; w < 8; w++) begin
            reg_write(csw_pkg::CTRL_ADDR, {fld(4'(7 - w), csw_pkg::RCV_NONE, 1'b0, 1'b1, 1'b0),
                                           fld(4'(w), csw_pkg::RCV_NONE, 1'b0, 1'b1, 1'b0)});
            acc(1'b0, 1'b0, 1'b0);
            chk(32'(lat), 32'(w + 1));
            chk(32'(sel), 32'(w + 1));
            acc(1'b1, 1'b0, 1'b1);
            chk(32'(lat), 32'(8 - w));
            chk(32'(sel), 32'(8 - w));
        end
        // recovery codes after reads, none after the following write
        for (int r = 0; r < 3; r++) begin
            reg_write(csw_pkg::CTRL_ADDR,
                      {fld(4'h0, 2'(r), 1'b0, 1'b1, 1'b0), fld(4'h0, 2'(r), 1'b0, 1'b1, 1'b0)});
            acc(r[0], 1'b1, 1'b1);
            chk(32'(read_recovery_count), 32'(r == 2 ? 0 : 2 - r));
            acc(r[0], 1'b0, 1'b1);
            chk(32'(read_recovery_count), 32'h0000_0000);
        end
        // bus width per space
        for (int b = 0; b < 2; b++) begin
            reg_write(csw_pkg::CTRL_ADDR, {fld(4'h0, csw_pkg::RCV_NONE, ~b[0], 1'b1, 1'b0),
                                           fld(4'h0, csw_pkg::RCV_NONE, b[0], 1'b1, 1'b0)});
            acc(1'b0, 1'b0, 1'b0);
            chk(32'(bw), 32'(b));
            acc(1'b1, 1'b0, 1'b1);
            chk(32'(bw), 32'(1 - b));
        end
        // enable, scope and window combinations
        for (int k = 0; k < 8; k++) begin
            reg_write(csw_pkg::CTRL_ADDR, {fld(4'h0, csw_pkg::RCV_NONE, 1'b0, k[2], 1'b0),
                                           fld(4'h0, csw_pkg::RCV_NONE, 1'b0, k[2], k[1])});
            acc(1'b0, 1'b0, k[0]);
            chk(32'(sel), 32'(k[2] && (!k[1] || k[0])));
            chk(32'(lat), 32'h0000_0001);
            acc(1'b1, 1'b0, k[0]);
            chk(32'(sel), 32'(k[2] && k[0]));
            reg_read(csw_pkg::STAT_ADDR, rd);
            chk(rd, (32'h0000_0001 << csw_pkg::ST_SPACE_BIT)
                    | (32'(k[2] && k[0]) << csw_pkg::ST_SEL_BIT));
        end
        // waits extended by the external device
        reg_write(csw_pkg::CTRL_ADDR,
                  {16'h0000, fld(csw_pkg::WAIT_EXT, csw_pkg::RCV_NONE, 1'b0, 1'b1, 1'b0)});
        for (int h = 0; h < 9; h += 3) begin
            hold  <= 4'(h);
            armed <= 1'b1;
            acc(1'b0, 1'b0, 1'b0);
            chk(32'(lat >= (h == 0 ? 2 : h + 1) && lat <= (h == 0 ? 2 : h + 4)), 32'h1);
            armed <= 1'b0;
            @(posedge clk);
        end
        end_sim();
    end
endmodule : csw_cs23_tb_top
`default_nettype wire
